// ===== core/ufc_pkg.sv
// Purpose: Shared constants and types for the UART FIFO control block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes:   Both FIFOs are 32 bytes deep
package ufc_pkg;
    localparam int          FIFO_DEPTH   = 32;
    localparam int          CNT_W        = 6;
    // Register byte offsets
    localparam logic [3:0]  OFS_CONTROL  = 4'h0;
    localparam logic [3:0]  OFS_DATA     = 4'h4;
    localparam logic [3:0]  OFS_STATUS   = 4'h8;
    localparam logic [3:0]  OFS_LEVEL    = 4'hc;
    // Control field positions
    localparam int          BIT_ENABLE   = 0;
    localparam int          BIT_RX_FLUSH = 1;
    localparam int          BIT_TX_FLUSH = 2;
    localparam int          BIT_DMA_MODE = 3;
    localparam int          TX_TRIG_LO   = 4;
    localparam int          RX_TRIG_LO   = 6;
    localparam logic [7:0]  CONTROL_RST  = 8'h00;
    // Threshold tables
    localparam logic [5:0]  RX_TRIG_0    = 6'h08;
    localparam logic [5:0]  RX_TRIG_1    = 6'h10;
    localparam logic [5:0]  RX_TRIG_2    = 6'h18;
    localparam logic [5:0]  RX_TRIG_3    = 6'h1c;
    localparam logic [5:0]  TX_TRIG_0    = 6'h10;
    localparam logic [5:0]  TX_TRIG_1    = 6'h08;
    localparam logic [5:0]  TX_TRIG_2    = 6'h18;
    localparam logic [5:0]  TX_TRIG_3    = 6'h1e;
    localparam logic [5:0]  CNT_FULL     = 6'h20;
    localparam logic [5:0]  CNT_ONE      = 6'h01;
    localparam logic [5:0]  CNT_ZERO     = 6'h00;
    localparam logic [4:0]  PTR_ZERO     = 5'h00;

    typedef struct packed {
        logic [1:0] rx_threshold_select;
        logic [1:0] tx_threshold_select;
        logic       dma_mode;
        logic       tx_fifo_flush;
        logic       rx_fifo_flush;
        logic       fifo_enable;
    } ufc_control_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ufc_byte_t;
endpackage

// ===== core/ufc_top.sv
// Purpose: FIFO enable, flush, thresholds and DMA ready pins of one channel
// Assumes: Serializer on the same clock; time-out event is one-cycle pulse
// Notes:   Flush bits self-clear after one cycle of flushing
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module ufc_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Transmit serializer side
    output ufc_pkg::ufc_byte_t tx_out,
    input  wire logic        tx_take,
    // Receive deserializer side
    input  wire ufc_pkg::ufc_byte_t rx_in,
    input  wire logic        rx_timeout,
    // Events and DMA pins
    output logic             rx_threshold_event,
    output logic             tx_empty_event,
    output logic             tx_dma_ready_n,
    output logic             rx_dma_ready_n
);
    logic        rst_s1;
    logic        rst_s2;
    ufc_pkg::ufc_control_t ctrl;
    logic [7:0]  tx_mem [ufc_pkg::FIFO_DEPTH];
    logic [7:0]  rx_mem [ufc_pkg::FIFO_DEPTH];
    logic [4:0]  tx_rd;
    logic [4:0]  tx_wr;
    logic [4:0]  rx_rd;
    logic [4:0]  rx_wr;
    logic [5:0]  tx_cnt;
    logic [5:0]  rx_cnt;
    logic [5:0]  rx_trig;
    logic [5:0]  tx_trig;
    logic [5:0]  cap;
    logic        ack;
    logic        ctrl_wr;
    logic        data_wr;
    logic        data_rd;
    logic        tx_push;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_pop;
    logic        timeout_seen;
    logic [31:0] next_readdata;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    function automatic logic [5:0] rx_level(input logic [1:0] code);
        unique case (code)
            2'b00: rx_level = ufc_pkg::RX_TRIG_0;
            2'b01: rx_level = ufc_pkg::RX_TRIG_1;
            2'b10: rx_level = ufc_pkg::RX_TRIG_2;
            2'b11: rx_level = ufc_pkg::RX_TRIG_3;
        endcase
    endfunction

    function automatic logic [5:0] tx_level(input logic [1:0] code);
        unique case (code)
            2'b00: tx_level = ufc_pkg::TX_TRIG_0;
            2'b01: tx_level = ufc_pkg::TX_TRIG_1;
            2'b10: tx_level = ufc_pkg::TX_TRIG_2;
            2'b11: tx_level = ufc_pkg::TX_TRIG_3;
        endcase
    endfunction

    // Pointers wrap at the depth by their width alone
    function automatic logic [4:0] ptr_inc(input logic [4:0] ptr);
        ptr_inc = ptr + 5'h01;
    endfunction

    // Push and pop are gated, so the count never leaves 0..32
    function automatic logic [5:0] next_count(input logic [5:0] cnt,
                                              input logic       push,
                                              input logic       pop);
        next_count = cnt + {5'h00, push} - {5'h00, pop};
    endfunction

    assign rx_trig = rx_level(ctrl.rx_threshold_select);
    assign tx_trig = tx_level(ctrl.tx_threshold_select);
    // Disabled FIFOs behave as single holding registers
    assign cap = ctrl.fifo_enable ? ufc_pkg::CNT_FULL
                                  : ufc_pkg::CNT_ONE;

    // Bus: one wait cycle, then acknowledge
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;

    assign ctrl_wr = avs_write & ack & avs_byteenable[0]
                     & (avs_address == ufc_pkg::OFS_CONTROL);
    assign data_wr = avs_write & ack & avs_byteenable[0]
                     & (avs_address == ufc_pkg::OFS_DATA);
    assign data_rd = avs_read & ack
                     & (avs_address == ufc_pkg::OFS_DATA);

    // Control register
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            ctrl <= ufc_pkg::CONTROL_RST;
        end else if (ctrl_wr) begin
            ctrl.fifo_enable <= avs_writedata[ufc_pkg::BIT_ENABLE];
            // Other fields only land with the enable bit set
            if (avs_writedata[ufc_pkg::BIT_ENABLE]) begin
                ctrl.rx_fifo_flush <= avs_writedata[ufc_pkg::BIT_RX_FLUSH];
                ctrl.tx_fifo_flush <= avs_writedata[ufc_pkg::BIT_TX_FLUSH];
                ctrl.dma_mode <= avs_writedata[ufc_pkg::BIT_DMA_MODE];
                ctrl.tx_threshold_select <=
                    avs_writedata[ufc_pkg::TX_TRIG_LO +: 2];
                ctrl.rx_threshold_select <=
                    avs_writedata[ufc_pkg::RX_TRIG_LO +: 2];
            end else begin
                // Flush bits must not outlive the write
                ctrl.rx_fifo_flush <= 1'b0;
                ctrl.tx_fifo_flush <= 1'b0;
            end
        end else begin
            ctrl.rx_fifo_flush <= 1'b0;
            ctrl.tx_fifo_flush <= 1'b0;
        end
    end

    // Writes into a full FIFO are dropped
    assign tx_push = data_wr & (tx_cnt < cap) & ~ctrl.tx_fifo_flush;
    assign tx_pop  = tx_take & (tx_cnt != ufc_pkg::CNT_ZERO);
    assign rx_push = rx_in.valid & (rx_cnt < cap) & ~ctrl.rx_fifo_flush;
    assign rx_pop  = data_rd & (rx_cnt != ufc_pkg::CNT_ZERO);

    // Transmit FIFO; the shift register outside is never touched
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            tx_wr <= ufc_pkg::PTR_ZERO;
        end else if (ctrl.tx_fifo_flush) begin
            tx_wr <= ufc_pkg::PTR_ZERO;
        end else if (tx_push) begin
            tx_wr <= ptr_inc(tx_wr);
        end
    end

    // A pop of an empty FIFO leaves the pointer alone
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            tx_rd <= ufc_pkg::PTR_ZERO;
        end else if (ctrl.tx_fifo_flush) begin
            tx_rd <= ufc_pkg::PTR_ZERO;
        end else if (tx_pop) begin
            tx_rd <= ptr_inc(tx_rd);
        end
    end

    // Flush wins over a push or pop in the same cycle
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            tx_cnt <= ufc_pkg::CNT_ZERO;
        end else if (ctrl.tx_fifo_flush) begin
            tx_cnt <= ufc_pkg::CNT_ZERO;
        end else begin
            tx_cnt <= next_count(tx_cnt, tx_push, tx_pop);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (tx_push) begin
            tx_mem[tx_wr] <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            tx_out <= '0;
        end else begin
            tx_out.valid <= tx_pop;
            tx_out.data  <= tx_mem[tx_rd];
        end
    end

    // Receive FIFO; the shift register outside is never touched
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            rx_wr <= ufc_pkg::PTR_ZERO;
        end else if (ctrl.rx_fifo_flush) begin
            rx_wr <= ufc_pkg::PTR_ZERO;
        end else if (rx_push) begin
            rx_wr <= ptr_inc(rx_wr);
        end
    end

    // Reading an empty FIFO gives a stale byte and no pop
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            rx_rd <= ufc_pkg::PTR_ZERO;
        end else if (ctrl.rx_fifo_flush) begin
            rx_rd <= ufc_pkg::PTR_ZERO;
        end else if (rx_pop) begin
            rx_rd <= ptr_inc(rx_rd);
        end
    end

    // Bytes arriving during the flush cycle are lost
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            rx_cnt <= ufc_pkg::CNT_ZERO;
        end else if (ctrl.rx_fifo_flush) begin
            rx_cnt <= ufc_pkg::CNT_ZERO;
        end else begin
            rx_cnt <= next_count(rx_cnt, rx_push, rx_pop);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rx_push) begin
            rx_mem[rx_wr] <= rx_in.data;
        end
    end

    // Time-out holds receive ready until the FIFO drains
    // A time-out in the same cycle as the clear wins
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            timeout_seen <= 1'b0;
        end else if (rx_timeout & ctrl.fifo_enable) begin
            timeout_seen <= 1'b1;
        end else if (rx_cnt == ufc_pkg::CNT_ZERO) begin
            timeout_seen <= 1'b0;
        end
    end

    // Receive event tracks level against threshold
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            rx_threshold_event <= 1'b0;
        end else if (ctrl.fifo_enable) begin
            rx_threshold_event <= (rx_cnt >= rx_trig);
        end else begin
            rx_threshold_event <= (rx_cnt != ufc_pkg::CNT_ZERO);
        end
    end

    // Transmit event; a lone holding register reports empty only
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            tx_empty_event <= 1'b0;
        end else if (ctrl.fifo_enable) begin
            tx_empty_event <= (tx_cnt < tx_trig);
        end else begin
            tx_empty_event <= (tx_cnt == ufc_pkg::CNT_ZERO);
        end
    end

    // DMA ready pins, registered
    // Mode 1 holds the pin between threshold and full
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            tx_dma_ready_n <= 1'b1;
        end else if (!ctrl.fifo_enable || !ctrl.dma_mode) begin
            tx_dma_ready_n <= (tx_cnt != ufc_pkg::CNT_ZERO);
        end else if (tx_cnt == ufc_pkg::CNT_FULL) begin
            tx_dma_ready_n <= 1'b1;
        end else if (tx_cnt < tx_trig) begin
            tx_dma_ready_n <= 1'b0;
        end
    end

    // Mode 1: low from threshold or time-out until empty
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            rx_dma_ready_n <= 1'b1;
        end else if (!ctrl.fifo_enable || !ctrl.dma_mode) begin
            rx_dma_ready_n <= (rx_cnt == ufc_pkg::CNT_ZERO);
        end else if (rx_cnt == ufc_pkg::CNT_ZERO) begin
            rx_dma_ready_n <= 1'b1;
        end else if (rx_cnt >= rx_trig || timeout_seen) begin
            rx_dma_ready_n <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (avs_address)
            ufc_pkg::OFS_CONTROL: next_readdata[7:0] = ctrl;
            ufc_pkg::OFS_DATA:    next_readdata[7:0] = rx_mem[rx_rd];
            ufc_pkg::OFS_STATUS: begin
                next_readdata[0] = ctrl.fifo_enable;
                next_readdata[1] = timeout_seen;
                next_readdata[2] = rx_threshold_event;
                next_readdata[3] = tx_empty_event;
                next_readdata[4] = rx_dma_ready_n;
                next_readdata[5] = tx_dma_ready_n;
            end
            ufc_pkg::OFS_LEVEL: begin
                next_readdata[5:0]  = rx_cnt;
                next_readdata[13:8] = tx_cnt;
            end
            default:              next_readdata = 32'h0000_0000;
        endcase
    end

    // Loaded in the wait cycle so the answer stands from a flop
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack) begin
            avs_readdata <= next_readdata;
        end
    end
endmodule

// ===== test/ufc_chk.sv
// Purpose: Port assertions for the FIFO control block
// Assumes: Bound to ufc_top; one clock domain
// Notes:   DMA mode is not visible here, so no check depends on it
`timescale 1ns/1ns
module ufc_chk (
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rstn,
    // Register bus
    input wire logic [3:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    // Stream and events
    input wire ufc_pkg::ufc_byte_t tx_out,
    input wire logic               tx_take,
    input wire logic               rx_threshold_event,
    input wire logic               tx_empty_event,
    input wire logic               rx_dma_ready_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic req;
    logic ctl_wr;
    assign req = avs_read | avs_write;
    assign ctl_wr = avs_write & !avs_waitrequest & avs_address == 4'h0;
    wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("New request had no wait state");
    ack_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("Request not answered after one wait");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
        avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("Unmapped read not zero");
    ctrl_upper_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == 4'h0 |-> avs_readdata[31:8] == 24'h0)
        else $error("Control read upper bits set");
    tx_pop_a: assert property (tx_out.valid |-> $past(tx_take))
        else $error("Byte sent without a take");
    tx_flush_a: assert property (
        ctl_wr && avs_writedata[2] && avs_writedata[0] |-> ##[1:4] tx_empty_event)
        else $error("Transmit flush left data");
    rx_flush_a: assert property (
        ctl_wr && avs_writedata[1] && avs_writedata[0]
        |-> ##[1:4] (rx_dma_ready_n && !rx_threshold_event))
        else $error("Receive flush left data");
    tx_evt_fall_a: assert property ($fell(tx_empty_event) |->
        $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("Transmit event fell without a write");
    rx_evt_fall_a: assert property ($fell(rx_threshold_event) |->
        $past(req) || $past(req, 2) || $past(req, 3))
        else $error("Receive event fell without an access");
endmodule

// ===== test/ufc_line_model.sv
// Purpose: Serializer and deserializer stand-in on the stream side
// Assumes: Bench asks for each push, take and time-out
// Notes:   Idle data flips to its own inverse every cycle after the last byte
`timescale 1ns/1ns
module ufc_line_model (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // Bench requests
    input  wire logic               push_req,
    input  wire logic               take_req,
    input  wire logic               to_req,
    // Block side
    input  wire ufc_pkg::ufc_byte_t tx_out,
    output ufc_pkg::ufc_byte_t      rx_in,
    output logic                    tx_take,
    output logic                    rx_timeout,
    output logic [7:0]              tx_last
);
    logic [7:0] next_byte;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            next_byte <= 8'h00;
            rx_in <= '0;
        end else begin
            rx_in.valid <= push_req;
            rx_in.data <= push_req ? next_byte : ~rx_in.data;
            next_byte <= next_byte + {7'h0, push_req};
        end
    end
    // Takes only when asked, so stalls are the default
    always_ff @(posedge clk_sys) begin
        tx_take <= take_req;
        rx_timeout <= to_req;
        if (tx_out.valid) tx_last <= tx_out.data;
    end
endmodule

// ===== test/ufc_top_tb_top.sv
// Purpose: Directed bench for FIFO control, thresholds and ready pins
// Assumes: One wait state per bus access
// Notes:   Ready pins lag counts by a cycle, so checks wait
`timescale 1ns/1ns
module ufc_top_tb_top;
    logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    ufc_pkg::ufc_byte_t tx_out, rx_in;
    logic tx_take, rx_timeout, rx_threshold_event, tx_empty_event;
    logic tx_dma_ready_n, rx_dma_ready_n, push_req, take_req, to_req;
    logic [7:0] tx_last, base;
    int num_errors, checks, cycles, n;
    int rxt[4] = '{8, 16, 24, 28};
    int txt[4] = '{16, 8, 24, 30};
    ufc_top ufc_top_i (.clk_sys(clk_sys), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_out(tx_out),
        .tx_take(tx_take), .rx_in(rx_in), .rx_timeout(rx_timeout),
        .rx_threshold_event(rx_threshold_event),
        .tx_empty_event(tx_empty_event),
        .tx_dma_ready_n(tx_dma_ready_n), .rx_dma_ready_n(rx_dma_ready_n));
    ufc_line_model ufc_line_model_i (.clk_sys(clk_sys), .rstn(rstn),
        .push_req(push_req), .take_req(take_req), .to_req(to_req),
        .tx_out(tx_out), .rx_in(rx_in), .tx_take(tx_take),
        .rx_timeout(rx_timeout), .tx_last(tx_last));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic val(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: value %h, want %h", $time, g, e);
        end
    endtask
    task automatic pin(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: pin %b, want %b", $time, g, e);
        end
    endtask
    // Holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        val(q, e);
    endtask
    task automatic push;
        push_req <= 1'b1;
        tick(1);
        push_req <= 1'b0;
        tick(4);
        base++;
    endtask
    task automatic take;
        take_req <= 1'b1;
        tick(1);
        take_req <= 1'b0;
        tick(4);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        {rstn, avs_read, avs_write, push_req, take_req, to_req} = 6'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        base = 8'h00;
        tick(10);
        rstn <= 1'b1;
        tick(3);
        rdc(4'h0, 32'h0);
        pin(tx_dma_ready_n, 1'b0);
        pin(rx_dma_ready_n, 1'b1);
        rdc(4'h8, 32'h18);
        rdc(4'h2, 32'h0);
        bus(1'b1, 4'h4, 32'h5a);
        bus(1'b1, 4'h4, 32'h66);
        tick(2);
        pin(tx_dma_ready_n, 1'b1);
        rdc(4'hc, 32'h100);
        take();
        val({24'h0, tx_last}, 32'h5a);
        bus(1'b1, 4'h0, 32'h09);
        rdc(4'h0, 32'h09);
        bus(1'b1, 4'h0, 32'hf0);
        rdc(4'h0, 32'h08);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 4'h0, 32'h0b | (i << 6));
            n = 0;
            while (rx_threshold_event !== 1'b1 && n < 40) begin
                push();
                n++;
            end
            val(n, rxt[i]);
            pin(rx_dma_ready_n, 1'b0);
            while (n < 34) begin
                push();
                n++;
            end
            rdc(4'hc, 32'h20);
            for (int k = 0; k < 32; k++) begin
                pin(rx_dma_ready_n, 1'b0);
                rdc(4'h4, {24'h0, 8'(k) + base - 8'd34});
            end
            tick(2);
            pin(rx_dma_ready_n, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 4'h0, 32'h0d | (i << 4));
            for (int k = 0; k < 34; k++) bus(1'b1, 4'h4, 32'(k));
            tick(2);
            rdc(4'hc, 32'h2000);
            pin(tx_dma_ready_n, 1'b1);
            for (int k = 31; k >= 0; k--) begin
                take();
                pin(tx_empty_event, k < txt[i]);
                pin(tx_dma_ready_n, !(k < txt[i]));
            end
        end
        bus(1'b1, 4'h0, 32'h01);
        tick(2);
        pin(tx_dma_ready_n, 1'b0);
        push();
        pin(rx_dma_ready_n, 1'b0);
        bus(1'b0, 4'h4, 32'h0);
        tick(2);
        pin(rx_dma_ready_n, 1'b1);
        bus(1'b1, 4'h0, 32'h09);
        push();
        pin(rx_dma_ready_n, 1'b1);
        to_req <= 1'b1;
        tick(1);
        to_req <= 1'b0;
        tick(4);
        pin(rx_dma_ready_n, 1'b0);
        bus(1'b1, 4'h0, 32'h0b);
        tick(2);
        rdc(4'hc, 32'h0);
        pin(rx_dma_ready_n, 1'b1);
        report_and_stop();
    end
endmodule
bind ufc_top ufc_chk ufc_chk_i (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_out(tx_out), .tx_take(tx_take),
    .rx_threshold_event(rx_threshold_event),
    .tx_empty_event(tx_empty_event), .rx_dma_ready_n(rx_dma_ready_n));
